// file: src/sar_ctrl_pkg.sv
// package: constants, states and carriers for the converter sequencer
// assumes one 40 MHz system clock
package sar_ctrl_pkg;
    localparam int CLK_PERIOD_PS = 25000;
    localparam int CONV_TIME_NS = 4700;
    // longest time rounds down
    localparam int CONV_CYCLES = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int RESULT_WIDTH = 14;
    localparam int BYTE_WIDTH = 8;
    localparam int CNT_WIDTH = 9;
    localparam logic [13:0] RESULT_RESET = 14'h0000;
    localparam logic [13:0] BIPOLAR_OFFSET = 14'h2000;

    typedef enum logic [2:0] {
        ST_SHUTDOWN = 3'b000,
        ST_ACQUIRE  = 3'b001,
        ST_CONVERT  = 3'b011,
        ST_DONE     = 3'b010,
        ST_READ     = 3'b110,
        ST_STANDBY  = 3'b100
    } seq_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic oeN;
    } bus_out_t;

    typedef struct packed {
        seq_state_t state;
        logic strobeLast;
        logic shutdownSel;
        logic refOn;
        logic eocN;
        logic [CNT_WIDTH-1:0] count;
        logic [13:0] result;
        bus_out_t bus;
    } seq_state_reg_t;
endpackage

// file: src/sar_result_reg.sv
// result holding register with byte steering onto the shared pins
// assumes sampled data arrive in the clock domain of clk_sys
`timescale 1ns/1ps
module sar_result_reg #(
    parameter int WIDTH = 14
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic load,
    input wire logic [WIDTH-1:0] loadData,
    input wire logic upperSel,
    output logic [7:0] byteOut,
    output logic [WIDTH-1:0] stored
);
    logic [WIDTH-1:0] store_reg;
    logic [15:0] wide;

    initial
    begin
        if (WIDTH > 16 || WIDTH < 9)
            $error("result width out of range");
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
            store_reg <= '0;
        else if (clkEn && load)
            store_reg <= loadData;
    end

    always_comb
    begin
        wide = 16'h0000;
        // upper bits above result read as zero
        wide[WIDTH-1:0] = store_reg;
    end

    assign stored = store_reg;
    // RULE14 byte choice
    // RULE20 shared byte lanes
    assign byteOut = upperSel ? wide[15:8] : wide[7:0];
endmodule

// file: src/sar_adc_parallel_readout_ctrl.sv
// sequencer for strobe-driven acquisition, conversion and byte readout
// assumes all inputs synchronous to clk_sys; pin level resolution outside
// Operation
// RULE1 - first strobe fall with select low wakes device into acquisition
// RULE2 - strobe fall with select high ignored as a start
// RULE3 - host waits 12ms after shutdown wake before converting
// RULE4 - select at second fall chooses standby (low) or shutdown (high)
// RULE5 - shutdown turns reference off after conversion; standby keeps it on
// RULE6 - in standby, strobe fall with select low starts acquisition
// RULE7 - in shutdown, strobe fall with select low re-enables reference, acquires
// RULE8 - second strobe fall ends acquisition and starts conversion
// RULE9 - conversion finishes within 4.7us of second fall
// RULE10 - end-of-conversion output goes low when result valid
// RULE11 - data pins high impedance during acquisition and conversion
// RULE12 - third fall with select high drives data onto bus
// RULE13 - strobe high releases bus, then await next cycle
// RULE14 - byte-select low gives low byte, high gives high byte
// RULE15 - two top bits of high byte read zero
// RULE16 - result is 14 bits on three-state outputs
// RULE17 - offset binary for bipolar, straight binary for unipolar build
// RULE18 - host should pick shutdown for lowest current
// RULE19 - host should switch multiplexer right after acquisition
// RULE20 - low byte bits 0-7, high byte bits 8-13 on same pins
`timescale 1ns/1ps
module sar_adc_parallel_readout_ctrl #(
    parameter int RESULT_BITS = sar_ctrl_pkg::RESULT_WIDTH,
    parameter int CONV_LEN = sar_ctrl_pkg::CONV_CYCLES,
    parameter bit BIPOLAR = 1'b1
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic convStrobeN,
    input wire logic readSelect,
    input wire logic upper_byte_select,
    input wire logic [RESULT_BITS-1:0] sampleCode,
    output logic sampleHold,
    output logic sampleTake,
    output logic refEnable,
    output logic eocN,
    output logic [7:0] result_bitsOut,
    output logic result_bitsOeN
);
    sar_ctrl_pkg::seq_state_reg_t s_reg;
    sar_ctrl_pkg::seq_state_reg_t s_next;
    logic strobeFall;
    logic loadResult;
    logic [RESULT_BITS-1:0] codedSample;
    logic [7:0] byteVal;
    logic [RESULT_BITS-1:0] storedVal;

    initial
    begin
        if (RESULT_BITS != 14)
            $error("result width must be 14");
        if (CONV_LEN < 1 || CONV_LEN >= (1 << sar_ctrl_pkg::CNT_WIDTH))
            $error("conversion length out of range");
    end

    // RULE17 output coding
    assign codedSample = BIPOLAR ? (sampleCode ^ sar_ctrl_pkg::BIPOLAR_OFFSET) : sampleCode;
    assign strobeFall = s_reg.strobeLast && !convStrobeN;

    // RULE16 result store
    sar_result_reg #(
        .WIDTH(RESULT_BITS)
    ) u_result (
        .clk_sys(clk_sys),
        .srst(srst),
        .clkEn(clkEn),
        .load(loadResult),
        .loadData(codedSample),
        .upperSel(upper_byte_select),
        .byteOut(byteVal),
        .stored(storedVal)
    );

    always_comb
    begin
        s_next = s_reg;
        loadResult = 1'b0;
        s_next.strobeLast = convStrobeN;
        s_next.result = storedVal;
        case (s_reg.state)
            sar_ctrl_pkg::ST_SHUTDOWN, sar_ctrl_pkg::ST_STANDBY:
            begin
                // RULE2 select high ignored
                if (strobeFall && !readSelect)
                begin
                    // RULE1 RULE6 RULE7 wake and acquire
                    s_next.state = sar_ctrl_pkg::ST_ACQUIRE;
                    s_next.refOn = 1'b1;
                    s_next.eocN = 1'b1;
                end
            end
            sar_ctrl_pkg::ST_ACQUIRE:
            begin
                if (strobeFall)
                begin
                    // RULE8 enter hold
                    // RULE4 latch power choice
                    s_next.state = sar_ctrl_pkg::ST_CONVERT;
                    s_next.shutdownSel = readSelect;
                    s_next.count = '0;
                end
            end
            sar_ctrl_pkg::ST_CONVERT:
            begin
                // RULE9 bounded conversion time
                if (s_reg.count >= sar_ctrl_pkg::CNT_WIDTH'(CONV_LEN - 2))
                begin
                    loadResult = 1'b1;
                    // RULE10 flag result valid
                    s_next.eocN = 1'b0;
                    s_next.state = sar_ctrl_pkg::ST_DONE;
                    // RULE5 reference off in shutdown
                    s_next.refOn = !s_reg.shutdownSel;
                end
                else
                begin
                    s_next.count = s_reg.count + 1'b1;
                end
            end
            sar_ctrl_pkg::ST_DONE:
            begin
                if (strobeFall && readSelect)
                begin
                    // RULE12 load result onto bus
                    s_next.state = sar_ctrl_pkg::ST_READ;
                end
                else if (strobeFall)
                begin
                    // new cycle without reading
                    s_next.state = sar_ctrl_pkg::ST_ACQUIRE;
                    s_next.refOn = 1'b1;
                    s_next.eocN = 1'b1;
                end
            end
            sar_ctrl_pkg::ST_READ:
            begin
                if (convStrobeN)
                begin
                    // RULE13 release and wait
                    s_next.eocN = 1'b1;
                    s_next.state = s_reg.shutdownSel ? sar_ctrl_pkg::ST_SHUTDOWN : sar_ctrl_pkg::ST_STANDBY;
                end
            end
            default:
            begin
                s_next.state = sar_ctrl_pkg::ST_SHUTDOWN;
            end
        endcase
        // RULE11 drive only while reading
        s_next.bus.oeN = !(s_next.state == sar_ctrl_pkg::ST_READ);
        // RULE14 RULE15 byte on bus
        s_next.bus.data = (s_next.state == sar_ctrl_pkg::ST_READ) ? byteVal : 8'h00;
    end

    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            s_reg.state <= sar_ctrl_pkg::ST_SHUTDOWN;
            s_reg.strobeLast <= 1'b1;
            s_reg.shutdownSel <= 1'b1;
            s_reg.refOn <= 1'b0;
            s_reg.eocN <= 1'b1;
            s_reg.count <= '0;
            s_reg.result <= sar_ctrl_pkg::RESULT_RESET;
            s_reg.bus.data <= 8'h00;
            s_reg.bus.oeN <= 1'b1;
        end
        else if (clkEn)
        begin
            s_reg <= s_next;
        end
    end

    assign sampleHold = (s_reg.state == sar_ctrl_pkg::ST_CONVERT);
    assign sampleTake = loadResult;
    assign refEnable = s_reg.refOn;
    assign eocN = s_reg.eocN;
    assign result_bitsOut = s_reg.bus.data;
    assign result_bitsOeN = s_reg.bus.oeN;
endmodule

// file: sim/sar_ctrl_sva.sv
// checker: timing relations at the converter sequencer ports
// assumes checks pause while clkEn is low
`timescale 1ns/1ps
module sar_ctrl_sva #(
    parameter int CONV_LEN = 8
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic convStrobeN,
    input wire logic readSelect,
    input wire logic upper_byte_select,
    input wire logic sampleHold,
    input wire logic refEnable,
    input wire logic eocN,
    input wire logic [7:0] result_bitsOut,
    input wire logic result_bitsOeN
);
    logic shutSel_reg;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst || !clkEn);
    // select seen at the conversion start
    always_ff @(posedge clk_sys)
    begin
        if ($rose(sampleHold))
        begin
            shutSel_reg <= $past(readSelect);
        end
    end
    property p_wake;
        $fell(convStrobeN) && !readSelect && !refEnable |-> ##[1:2] refEnable;
    endproperty
    a_wake:
        assert property (p_wake) else $error("reference not woken");
    property p_ignore;
        $fell(convStrobeN) && readSelect && !refEnable && eocN |=> !refEnable [*2];
    endproperty
    a_ignore:
        assert property (p_ignore) else $error("start with select high taken");
    property p_conv;
        $rose(sampleHold) |-> ##[1:CONV_LEN] !eocN;
    endproperty
    a_conv:
        assert property (p_conv) else $error("conversion too long");
    property p_pwr;
        $fell(eocN) |-> refEnable == !shutSel_reg;
    endproperty
    a_pwr:
        assert property (p_pwr) else $error("wrong power state after conversion");
    property p_float;
        sampleHold |-> result_bitsOeN;
    endproperty
    a_float:
        assert property (p_float) else $error("bus driven while converting");
    property p_drive;
        $fell(convStrobeN) && readSelect && !eocN |-> ##[1:2] !result_bitsOeN;
    endproperty
    a_drive:
        assert property (p_drive) else $error("read did not drive bus");
    property p_release;
        !result_bitsOeN && convStrobeN |-> ##[1:2] (result_bitsOeN && eocN);
    endproperty
    a_release:
        assert property (p_release) else $error("bus not released");
    property p_zero;
        !result_bitsOeN && $past(upper_byte_select) |-> result_bitsOut[7:6] == 2'h0;
    endproperty
    a_zero:
        assert property (p_zero) else $error("high byte top bits set");
endmodule

// file: sim/sar_core_model.sv
// partner: analog core model presenting a raw code while held
// assumes the bench sets the code before the conversion starts
`timescale 1ns/1ps
module sar_core_model (
    input wire logic sampleHold,
    input wire logic [13:0] code,
    output logic [13:0] sampleCode
);
    // code shown only in hold
    always_comb
    begin
        sampleCode = sampleHold ? code : ~code;
    end
endmodule

// file: sim/sar_adc_parallel_readout_ctrl_test.sv
// bench: strobe-driven convert and read cycles with byte readout
// assumes design, checker and core model compiled first
`timescale 1ns/1ps
module sar_adc_parallel_readout_ctrl_test;
    localparam int CONV_LEN = 8;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic convStrobeN = 1'b1;
    logic readSelect = 1'b0;
    logic upper_byte_select = 1'b0;
    logic [13:0] code = 14'h0000;
    logic [13:0] sampleCode;
    logic sampleHold;
    logic refEnable;
    logic eocN;
    logic oeN;
    logic clkEn = 1'b1;
    logic sampleTake;
    int takeCount = 0;
    logic [7:0] dataOut;
    int badCount = 0;
    int checks = 0;
    always #12.5 clk_sys = ~clk_sys;
    // count capture pulses
    always @(posedge clk_sys)
    begin
        if (sampleTake === 1'b1)
            takeCount <= takeCount + 1;
    end
    sar_core_model u_sar_core_model (.sampleHold(sampleHold), .code(code), .sampleCode(sampleCode));
    sar_adc_parallel_readout_ctrl #(.CONV_LEN(CONV_LEN)) u_sar_adc_parallel_readout_ctrl (
        .clk_sys(clk_sys), .srst(srst), .clkEn(clkEn), .convStrobeN(convStrobeN), .readSelect(readSelect),
        .upper_byte_select(upper_byte_select), .sampleCode(sampleCode), .sampleHold(sampleHold),
        .sampleTake(sampleTake), .refEnable(refEnable), .eocN(eocN), .result_bitsOut(dataOut),
        .result_bitsOeN(oeN));
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0)
        begin
            $display("ALL CHECKS OK");
        end
        else
        begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [13:0] exp, input logic [13:0] got);
        checks++;
        if (got !== exp)
        begin
            badCount++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic strobe(input logic sel);
        @(negedge clk_sys);
        convStrobeN = 1'b0;
        readSelect = sel;
        repeat (2) @(negedge clk_sys);
        convStrobeN = 1'b1;
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic runCycle(input logic sel, input logic [13:0] raw);
        logic [13:0] exp;
        int n;
        int start;
        exp = raw ^ 14'h2000;
        code = raw;
        start = takeCount;
        strobe(1'b0);
        chk("acquire", 14'h2, {12'h0, refEnable, sampleHold});
        repeat (4) @(negedge clk_sys);
        strobe(sel);
        chk("bus in conversion", 14'h1, {13'h0, oeN});
        n = 0;
        while (eocN !== 1'b0 && n < CONV_LEN - 2)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (eocN !== 1'b0)
        begin
            badCount++;
            giveVerdict();
        end
        chk("power after conversion", {13'h0, !sel}, {13'h0, refEnable});
        chk("sample taken", 14'h1, 14'(takeCount - start));
        @(negedge clk_sys);
        convStrobeN = 1'b0;
        readSelect = 1'b1;
        upper_byte_select = 1'b0;
        repeat (2) @(negedge clk_sys);
        chk("low byte", {6'h0, exp[7:0]}, {6'h0, dataOut});
        upper_byte_select = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk("high byte", {8'h0, exp[13:8]}, {6'h0, dataOut});
        convStrobeN = 1'b1;
        repeat (2) @(negedge clk_sys);
        chk("release", 14'h3, {12'h0, oeN, eocN});
        $display("cycle done select %0d", sel);
    endtask
    initial
    begin
        repeat (10) @(negedge clk_sys);
        srst = 1'b0;
        chk("reset", 14'h3, {11'h0, refEnable, eocN, oeN});
        strobe(1'b1);
        chk("ignored start", 14'h0, {12'h0, refEnable, sampleHold});
        $display("ignored start done");
        clkEn = 1'b0;
        strobe(1'b0);
        chk("frozen", 14'h0, {12'h0, refEnable, sampleHold});
        clkEn = 1'b1;
        $display("frozen start done");
        runCycle(1'b1, 14'h1ABC);
        runCycle(1'b0, 14'h3FFF);
        runCycle(1'b1, 14'h0155);
        giveVerdict();
    end
endmodule
bind sar_adc_parallel_readout_ctrl sar_ctrl_sva #(.CONV_LEN(CONV_LEN)) u_sar_ctrl_sva (
    .clk_sys(clk_sys), .srst(srst), .clkEn(clkEn), .convStrobeN(convStrobeN), .readSelect(readSelect),
    .upper_byte_select(upper_byte_select), .sampleHold(sampleHold), .refEnable(refEnable),
    .eocN(eocN), .result_bitsOut(result_bitsOut), .result_bitsOeN(result_bitsOeN));
